// ---- shared/pmic_cfg_defines.svh ----
// Constants for the I2C configuration port: address, offsets, fields, resets
`ifndef PMIC_CFG_DEFINES_SVH
`define PMIC_CFG_DEFINES_SVH

// ****************************************************************
// Bus identity
// ****************************************************************
`define TARGET_ADDR   7'h70

// ****************************************************************
// Register offsets
// ****************************************************************
`define GEN_CFG_OFS   8'h01
`define RESTART_OFS   8'h06
`define WD_CFG2_OFS   8'h14

// ****************************************************************
// Field positions
// ****************************************************************
`define CHECK_EN_POS  0
`define WATCHDOG_ENABLE_BIT_POS     3
`define WD_MODE_POS   4

// ****************************************************************
// Reset values and check polynomial
// ****************************************************************
`define GEN_CFG_RST   8'h01
`define WD_CFG2_RST   8'h00
`define CRC_POLY      8'h07

`endif

// ---- shared/pmic_cfg_pkg.sv ----
// Types for the I2C configuration port
package pmic_cfg_pkg;

    // ****************************************************************
    // Serial engine states, one-hot
    // ****************************************************************
    typedef enum logic [6:0] {
        st_idle    = 7'h01,
        st_addr    = 7'h02,
        st_ack_adr = 7'h04,
        st_rx      = 7'h08,
        st_ack_rx  = 7'h10,
        st_tx      = 7'h20,
        st_ack_tx  = 7'h40
    } i2c_state_t;

    // ****************************************************************
    // Whole state of the port
    // ****************************************************************
    typedef struct packed {
        logic       scl_m1;
        logic       scl_m2;
        logic       scl_m3;
        logic       sda_m1;
        logic       sda_m2;
        logic       sda_m3;
        logic       scl_f;
        logic       sda_f;
        i2c_state_t st;
        logic [7:0] sh;
        logic [3:0] bitc;
        logic       rw;
        logic [7:0] ptr;
        logic [1:0] cnt;
        logic [7:0] data;
        logic [7:0] crc;
        logic       pec_en;
        logic       watchdog_enable_bit;
        logic       wd_cr;
        logic       sda_oe;
        logic       sda_lvl;
        logic       restart;
        logic       mem_we;
        logic [7:0] mem_wa;
        logic [7:0] mem_wd;
    } port_state_t;

endpackage : pmic_cfg_pkg

// ---- rtl/cfg_reg_mem.sv ----
// Byte-wide register store with registered read data
`timescale 1ns/10ps

module cfg_reg_mem (
    // Clock
    input  wire logic       clk_sys,
    // Write side
    input  wire logic       we,
    input  wire logic [7:0] waddr,
    input  wire logic [7:0] wdata,
    // Read side
    input  wire logic [7:0] raddr,
    output logic      [7:0] rdata
);

    // Contents are not reset; they hold whatever the host wrote last
    logic [7:0] mem_q [256];

    // ****************************************************************
    // Write and registered read
    // ****************************************************************
    always_ff @(posedge clk_sys) begin
        if (we) begin
            mem_q[waddr] <= wdata;
        end
        rdata <= mem_q[raddr];
    end

endmodule : cfg_reg_mem

// ---- rtl/i2c_cfg_port.sv ----
// I2C target configuration port with write check byte, watchdog and restart controls
`timescale 1ns/10ps
`include "pmic_cfg_defines.svh"

// Notes on behaviour
// R1 - Answer at target address 0x70
// R2 - Check byte protection on after reset
// R3 - Check byte is CRC-8, poly x8+x2+x+1
// R4 - Config 0x01 bit 0 enables check byte
// R5 - Host appends check byte to writes
// R6 - Watchdog: challenge/response, windowed, or off
// R7 - Watchdog disabled after reset
// R8 - Register 0x14 bit 3 enables watchdog
// R9 - Write to 0x06 restarts with settings
// R10 - Host should disable watchdog, check first
// R11 - Bad check byte discards the write
module i2c_cfg_port (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic nrst,
    // I2C pins, open drain data
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      sda_o,
    output logic      sda_oe,
    // Controls to the device core
    output logic      pec_enable,
    output logic      watchdog_enable,
    output logic      watchdog_mode_cr,
    output logic      restart_pulse
);
    import pmic_cfg_pkg::*;

    port_state_t s_q;
    port_state_t s_d;
    logic [7:0]  mem_rdata;
    logic        scl_n;
    logic        sda_n;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_ev;
    logic        stop_ev;
    logic        commit;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // One byte through CRC-8, MSB first, zero start value
    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
        logic [7:0] r;
        r = c ^ b;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? ((r << 1) ^ `CRC_POLY) : (r << 1);
        end
        return r; // [R3]
    endfunction : crc8

    // Read view: control bits come from flops, the rest from the store
    function automatic logic [7:0] rd_byte(input logic [7:0] a, input port_state_t s, input logic [7:0] m);
        logic [7:0] r;
        r = m;
        if (a == `GEN_CFG_OFS) begin
            r = '0;
            r[`CHECK_EN_POS] = s.pec_en;
        end else if (a == `WD_CFG2_OFS) begin
            r = '0;
            r[`WATCHDOG_ENABLE_BIT_POS] = s.watchdog_enable_bit;
            r[`WD_MODE_POS] = s.wd_cr;
        end
        return r;
    endfunction : rd_byte

    // ****************************************************************
    // Register store
    // ****************************************************************
    cfg_reg_mem u_mem (
        .clk_sys (clk_sys),
        .we      (s_q.mem_we),
        .waddr   (s_q.mem_wa),
        .wdata   (s_q.mem_wd),
        .raddr   (s_q.ptr),
        .rdata   (mem_rdata)
    );

    // ****************************************************************
    // Pin filtering and bus events
    // ****************************************************************
    // Filtered level changes only when stages two and three agree
    always_comb begin
        scl_n    = (s_q.scl_m2 == s_q.scl_m3) ? s_q.scl_m3 : s_q.scl_f;
        sda_n    = (s_q.sda_m2 == s_q.sda_m3) ? s_q.sda_m3 : s_q.sda_f;
        scl_rise = scl_n & ~s_q.scl_f;
        scl_fall = ~scl_n & s_q.scl_f;
        start_ev = s_q.scl_f & scl_n & s_q.sda_f & ~sda_n;
        stop_ev  = s_q.scl_f & scl_n & ~s_q.sda_f & sda_n;
    end

    // Write is taken at stop only when complete and, with checking on, clean
    always_comb begin
        if (s_q.pec_en) begin
            commit = !s_q.rw && s_q.cnt == 2'd3 && s_q.crc == 8'h00; // [R11] [R3]
        end else begin
            commit = !s_q.rw && s_q.cnt == 2'd2;
        end
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        s_d         = s_q;
        s_d.scl_m1  = scl_i;
        s_d.scl_m2  = s_q.scl_m1;
        s_d.scl_m3  = s_q.scl_m2;
        s_d.sda_m1  = sda_i;
        s_d.sda_m2  = s_q.sda_m1;
        s_d.sda_m3  = s_q.sda_m2;
        s_d.scl_f   = scl_n;
        s_d.sda_f   = sda_n;
        s_d.mem_we  = 1'b0;
        s_d.restart = 1'b0;
        if (start_ev) begin
            // Repeated start keeps the pointer for a following read
            s_d.st     = st_addr;
            s_d.bitc   = '0;
            s_d.cnt    = '0;
            s_d.crc    = '0;
            s_d.sda_oe = 1'b0;
        end else if (stop_ev) begin
            s_d.st     = st_idle;
            s_d.sda_oe = 1'b0;
            if (commit && s_q.st != st_idle && s_q.st != st_addr) begin
                s_d.mem_we = 1'b1;
                s_d.mem_wa = s_q.ptr;
                s_d.mem_wd = s_q.data;
                if (s_q.ptr == `GEN_CFG_OFS) begin
                    s_d.pec_en = s_q.data[`CHECK_EN_POS]; // [R4]
                end
                if (s_q.ptr == `WD_CFG2_OFS) begin
                    s_d.watchdog_enable_bit = s_q.data[`WATCHDOG_ENABLE_BIT_POS];  // [R8]
                    s_d.wd_cr = s_q.data[`WD_MODE_POS]; // [R6]
                end
                if (s_q.ptr == `RESTART_OFS) begin
                    s_d.restart = 1'b1; // [R9]
                end
            end
        end else begin
            case (s_q.st)
                st_addr: begin
                    if (scl_rise) begin
                        s_d.sh   = {s_q.sh[6:0], sda_n};
                        s_d.bitc = s_q.bitc + 4'd1;
                    end else if (scl_fall && s_q.bitc == 4'd8) begin
                        if (s_q.sh[7:1] == `TARGET_ADDR) begin
                            s_d.st     = st_ack_adr; // [R1]
                            s_d.sda_oe = 1'b1;
                            s_d.rw     = s_q.sh[0];
                            s_d.crc    = crc8(s_q.crc, s_q.sh);
                        end else begin
                            s_d.st = st_idle;
                        end
                    end
                end
                st_ack_adr: begin
                    if (scl_fall) begin
                        s_d.bitc = '0;
                        if (s_q.rw) begin
                            s_d.st     = st_tx;
                            s_d.sh     = rd_byte(s_q.ptr, s_q, mem_rdata);
                            s_d.sda_oe = ~s_d.sh[7];
                        end else begin
                            s_d.st     = st_rx;
                            s_d.sda_oe = 1'b0;
                        end
                    end
                end
                st_rx: begin
                    if (scl_rise) begin
                        s_d.sh   = {s_q.sh[6:0], sda_n};
                        s_d.bitc = s_q.bitc + 4'd1;
                    end else if (scl_fall && s_q.bitc == 4'd8) begin
                        // Pointer, data, check byte; a fourth byte spoils the check so long writes drop
                        if (s_q.cnt == 2'd0) begin
                            s_d.ptr = s_q.sh;
                        end else if (s_q.cnt == 2'd1) begin
                            s_d.data = s_q.sh;
                        end
                        s_d.crc    = (s_q.cnt == 2'd3) ? 8'hff : crc8(s_q.crc, s_q.sh); // [R3] [R5] [R11]
                        s_d.cnt    = (s_q.cnt == 2'd3) ? s_q.cnt : s_q.cnt + 2'd1;
                        s_d.st     = st_ack_rx;
                        s_d.sda_oe = 1'b1;
                    end
                end
                st_ack_rx: begin
                    if (scl_fall) begin
                        s_d.st     = st_rx;
                        s_d.bitc   = '0;
                        s_d.sda_oe = 1'b0;
                    end
                end
                st_tx: begin
                    if (scl_fall) begin
                        s_d.bitc = s_q.bitc + 4'd1;
                        if (s_q.bitc == 4'd7) begin
                            s_d.st     = st_ack_tx;
                            s_d.sda_oe = 1'b0;
                        end else begin
                            s_d.sh     = {s_q.sh[6:0], 1'b0};
                            s_d.sda_oe = ~s_q.sh[6];
                        end
                    end
                end
                st_ack_tx: begin
                    // Pointer moves at the acknowledge so the store has time to answer
                    if (scl_rise) begin
                        s_d.rw = ~sda_n;
                        if (!sda_n) begin
                            s_d.ptr = s_q.ptr + 8'd1;
                        end
                    end else if (scl_fall) begin
                        s_d.bitc = '0;
                        if (s_q.rw) begin
                            s_d.st     = st_tx;
                            s_d.sh     = rd_byte(s_q.ptr, s_q, mem_rdata);
                            s_d.sda_oe = ~s_d.sh[7];
                        end else begin
                            s_d.st = st_idle;
                        end
                    end
                end
                default: begin
                    s_d.st = st_idle;
                end
            endcase
            // A not-acknowledge ends reading; rw cleared marks it
            if (s_q.st == st_ack_tx && scl_fall && !s_q.rw) begin
                s_d.rw = 1'b1;
            end
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s_q        <= '0;
            s_q.scl_m1 <= 1'b1;
            s_q.scl_m2 <= 1'b1;
            s_q.scl_m3 <= 1'b1;
            s_q.sda_m1 <= 1'b1;
            s_q.sda_m2 <= 1'b1;
            s_q.sda_m3 <= 1'b1;
            s_q.scl_f  <= 1'b1;
            s_q.sda_f  <= 1'b1;
            s_q.st     <= st_idle;
            s_q.rw     <= 1'b1;
            s_q.pec_en <= 1'(`GEN_CFG_RST >> `CHECK_EN_POS); // [R2]
            s_q.watchdog_enable_bit  <= 1'(`WD_CFG2_RST >> `WATCHDOG_ENABLE_BIT_POS);    // [R7]
            s_q.wd_cr  <= 1'(`WD_CFG2_RST >> `WD_MODE_POS);
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs are flop fields; the data pin only ever pulls low
    always_comb begin
        sda_o            = s_q.sda_lvl;
        sda_oe           = s_q.sda_oe;
        pec_enable       = s_q.pec_en;
        watchdog_enable  = s_q.watchdog_enable_bit;
        watchdog_mode_cr = s_q.wd_cr;
        restart_pulse    = s_q.restart;
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    a_addr_match: assert property ((s_q.st == st_ack_adr && $past(s_q.st) == st_addr) // [R1]
        |-> $past(s_q.sh[7:1]) == `TARGET_ADDR) else $error("Acked a foreign address");
    a_check_hold: assert property ((s_q.pec_en && !(s_d.mem_we && s_d.mem_wa == `GEN_CFG_OFS)) // [R2]
        |=> s_q.pec_en) else $error("Check enable dropped without a write");
    a_crc_gate: assert property (s_q.mem_we // [R3]
        |-> !$past(s_q.pec_en) || $past(s_q.crc) == 8'h00) else $error("Write taken with bad check byte");
    a_check_bit: assert property ((s_q.mem_we && s_q.mem_wa == `GEN_CFG_OFS) // [R4]
        |-> s_q.pec_en == s_q.mem_wd[`CHECK_EN_POS]) else $error("Check enable not from bit 0");
    a_wd_rise: assert property ($rose(s_q.watchdog_enable_bit) // [R7]
        |-> s_q.mem_we && s_q.mem_wa == `WD_CFG2_OFS) else $error("Watchdog on without a write");
    a_wd_bits: assert property ((s_q.mem_we && s_q.mem_wa == `WD_CFG2_OFS) // [R8]
        |-> s_q.watchdog_enable_bit == s_q.mem_wd[`WATCHDOG_ENABLE_BIT_POS] && s_q.wd_cr == s_q.mem_wd[`WD_MODE_POS])
        else $error("Watchdog fields not taken");
    a_restart_once: assert property (s_q.restart // [R9]
        |-> s_q.mem_we && s_q.mem_wa == `RESTART_OFS ##1 !s_q.restart) else $error("Bad restart pulse");
    a_bad_drop: assert property ((stop_ev && s_q.pec_en && s_q.cnt == 2'd3 && s_q.crc != 8'h00) // [R11]
        |=> !s_q.mem_we) else $error("Bad check byte not discarded");

endmodule : i2c_cfg_port

// ---- verification/i2c_host_model.sv ----
// Behavioural I2C host that drives the clock wire and pulls the data wire low
`timescale 1ns/10ps

module i2c_host_model (
    // Clock
    input  wire logic clk_sys,
    // Resolved data wire
    input  wire logic sda_wire,
    // Host drives
    output logic      scl,
    output logic      sda_low
);
    // Idle bus: clock high, data released to the pull-up
    initial begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end

    // ****************************************************************
    // Bit level
    // ****************************************************************
    // Eight cycles per phase, above the five-cycle minimum of the port
    task automatic half();
        repeat (8) @(negedge clk_sys);
    endtask : half

    // Data changes two cycles after the clock fall, so hold time is never zero
    task automatic bitio(input logic b, output logic s);
        repeat (2) @(negedge clk_sys);
        sda_low = ~b;
        half();
        scl = 1'b1;
        half();
        s   = sda_wire;
        scl = 1'b0;
    endtask : bitio

    // Also serves as repeated start when the clock is low
    task automatic start();
        repeat (2) @(negedge clk_sys);
        sda_low = 1'b0;
        half();
        scl = 1'b1;
        half();
        sda_low = 1'b1;
        half();
        scl = 1'b0;
    endtask : start

    task automatic stop();
        repeat (2) @(negedge clk_sys);
        sda_low = 1'b1;
        half();
        scl = 1'b1;
        half();
        sda_low = 1'b0;
        half();
    endtask : stop

    // ****************************************************************
    // Byte level, MSB first
    // ****************************************************************
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitio(d[i], s);
        end
        bitio(1'b1, s);
        ack = ~s;
    endtask : wbyte

    // A released data wire during the host's turn lets the target drive
    task automatic rbyte(output logic [7:0] d, input logic nack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitio(1'b1, s);
            d = {d[6:0], s};
        end
        bitio(nack, s);
    endtask : rbyte
endmodule : i2c_host_model

// ---- verification/pmic_i2c_config_pec_port_test.sv ----
// Self-checking testbench of the I2C configuration port
`timescale 1ns/10ps
`include "pmic_cfg_defines.svh"

`define CHECK(got, exp, msg) begin n_tests++; if ((got) !== (exp)) begin errors++; \
    $display("mismatch t=%0t %s", $time, msg); end end

module pmic_i2c_config_pec_port_test;
    import pmic_cfg_pkg::*;

    // ****************************************************************
    // Signals and instances
    // ****************************************************************
    logic clk_sys, nrst, scl, sda_low, sda_wire, sda_o, sda_oe;
    logic pec_enable, watchdog_enable, watchdog_mode_cr, restart_pulse;
    int   errors = 0;
    int   n_tests = 0;
    int   n_pulse = 0;
    logic [7:0] rd_q;
    localparam logic [7:0] addr_w = {`TARGET_ADDR, 1'b0};

    // Pull-up wire: low while either party pulls it
    assign sda_wire = ~(sda_low | (sda_oe & ~sda_o));

    i2c_host_model h (.clk_sys(clk_sys), .sda_wire(sda_wire), .scl(scl), .sda_low(sda_low));

    i2c_cfg_port uut (.clk_sys(clk_sys), .nrst(nrst), .scl_i(scl), .sda_i(sda_wire), .sda_o(sda_o),
        .sda_oe(sda_oe), .pec_enable(pec_enable), .watchdog_enable(watchdog_enable),
        .watchdog_mode_cr(watchdog_mode_cr), .restart_pulse(restart_pulse));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Pulses are single cycles, so every rising edge is counted
    always @(posedge clk_sys) begin
        if (restart_pulse === 1'b1) n_pulse++;
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
        c = c ^ b;
        for (int i = 0; i < 8; i++) c = c[7] ? ((c << 1) ^ `CRC_POLY) : (c << 1);
        return c;
    endfunction : crc8

    // Flip mask corrupts the check byte on purpose
    task automatic wr(input logic [7:0] r, input logic [7:0] d, input bit chk, input logic [7:0] flip);
        logic [7:0] c;
        logic       a;
        c = crc8(crc8(crc8(8'h00, addr_w), r), d) ^ flip;
        h.start();
        h.wbyte(addr_w, a);
        `CHECK(a, 1'b1, "address not acknowledged")
        h.wbyte(r, a);
        h.wbyte(d, a);
        if (chk) h.wbyte(c, a);
        h.stop();
        repeat (10) @(negedge clk_sys);
    endtask : wr

    task automatic rd(input logic [7:0] r, output logic [7:0] d);
        logic a;
        h.start();
        h.wbyte(addr_w, a);
        h.wbyte(r, a);
        h.start();
        h.wbyte(addr_w | 8'h01, a);
        h.rbyte(d, 1'b1);
        h.stop();
    endtask : rd

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        nrst = 1'b0;
        repeat (5) @(negedge clk_sys);
        `CHECK(pec_enable, 1'b1, "check byte off in reset")
        nrst = 1'b1;
        repeat (6) @(negedge clk_sys);
        `CHECK(pec_enable, 1'b1, "check byte off after reset")
        `CHECK(watchdog_enable, 1'b0, "watchdog on after reset")
        `CHECK(sda_oe, 1'b0, "data wire held after reset")
    endtask : t_reset

    // A neighbouring address must stay silent
    task automatic t_address();
        logic a;
        h.start();
        h.wbyte(8'he2, a);
        `CHECK(a, 1'b0, "foreign address acknowledged")
        h.stop();
    endtask : t_address

    task automatic t_watchdog();
        wr(`WD_CFG2_OFS, 8'h08, 1, 8'h00);
        `CHECK(watchdog_enable, 1'b1, "watchdog not enabled")
        `CHECK(watchdog_mode_cr, 1'b0, "mode not windowed")
        wr(`WD_CFG2_OFS, 8'h18, 1, 8'h00);
        `CHECK(watchdog_mode_cr, 1'b1, "mode not challenge")
        rd(`WD_CFG2_OFS, rd_q);
        `CHECK(rd_q, 8'h18, "watchdog config readback")
    endtask : t_watchdog

    // Corrupted, missing and trailing check bytes must all be dropped
    task automatic t_bad_check();
        logic a;
        wr(`WD_CFG2_OFS, 8'h00, 1, 8'h01);
        `CHECK(watchdog_enable, 1'b1, "write with bad check kept")
        wr(`WD_CFG2_OFS, 8'h00, 0, 8'h00);
        `CHECK(watchdog_enable, 1'b1, "write without check kept")
        // A zero byte after a good check byte sets the running check to 0xff
        h.start();
        h.wbyte(addr_w, a);
        h.wbyte(`WD_CFG2_OFS, a);
        h.wbyte(8'h00, a);
        h.wbyte(crc8(crc8(crc8(8'h00, addr_w), `WD_CFG2_OFS), 8'h00), a);
        h.wbyte(8'h00, a);
        h.stop();
        repeat (10) @(negedge clk_sys);
        `CHECK(watchdog_enable, 1'b1, "over-long write kept")
    endtask : t_bad_check

    // Two-byte read: the pointer steps on the host acknowledge
    task automatic t_burst();
        logic       a;
        logic [7:0] d0;
        wr(8'h13, 8'ha5, 1, 8'h00);
        h.start();
        h.wbyte(addr_w, a);
        h.wbyte(8'h13, a);
        h.start();
        h.wbyte(addr_w | 8'h01, a);
        h.rbyte(d0, 1'b0);
        h.rbyte(rd_q, 1'b1);
        h.stop();
        `CHECK(d0, 8'ha5, "first burst byte")
        `CHECK(rd_q, 8'h18, "second burst byte")
    endtask : t_burst

    task automatic t_restart();
        n_pulse = 0;
        wr(`RESTART_OFS, 8'h5a, 1, 8'h00);
        `CHECK(n_pulse, 1, "restart pulse count")
        `CHECK(watchdog_enable, 1'b1, "settings lost on restart")
    endtask : t_restart

    // Recommended bring-up: drop check byte, then watchdog
    task automatic t_disable();
        wr(`GEN_CFG_OFS, 8'h00, 1, 8'h00);
        `CHECK(pec_enable, 1'b0, "check byte not disabled")
        wr(`WD_CFG2_OFS, 8'h08, 0, 8'h00);
        `CHECK(watchdog_enable, 1'b1, "plain write refused")
        `CHECK(watchdog_mode_cr, 1'b0, "plain write not taken")
        wr(`WD_CFG2_OFS, 8'h00, 0, 8'h00);
        `CHECK(watchdog_enable, 1'b0, "watchdog not disabled")
        rd(`GEN_CFG_OFS, rd_q);
        `CHECK(rd_q, 8'h00, "config readback")
        wr(`GEN_CFG_OFS, 8'h01, 0, 8'h00);
        `CHECK(pec_enable, 1'b1, "check byte not re-enabled")
    endtask : t_disable

    // ****************************************************************
    // Verdict, main sequence and watchdog
    // ****************************************************************
    task automatic print_verdict();
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    initial begin
        nrst = 1'b0;
        t_reset();
        t_address();
        t_watchdog();
        t_burst();
        t_bad_check();
        t_restart();
        t_reset();
        t_watchdog();
        t_disable();
        print_verdict();
    end

    // Run needs about 12000 cycles
    initial begin
        repeat (80000) @(posedge clk_sys);
        errors++;
        $display("mismatch t=%0t run timed out", $time);
        print_verdict();
    end
endmodule : pmic_i2c_config_pec_port_test
